/* rca_alu.sv */
// Eight-bit arithmetic unit with carry, nibble carry and zero outputs.
// Assumes the caller picks which flags it keeps; purely combinational.
`include "rca_cfg.svh"
`default_nettype none

module rca_alu (
   input wire rca_pkg::rca_aluop_e op,
   input wire logic [`RCA_DATA_W-1:0] a,
   input wire logic [`RCA_DATA_W-1:0] w,
   input wire logic cin,
   output logic [`RCA_DATA_W-1:0] res,
   output logic cOut,
   output logic dcOut,
   output logic zOut
);

   logic [8:0] sum;
   logic [4:0] nib;

   // Subtract is a plus not-w plus one, so carry out means no borrow
   always_comb
   begin
      sum = 9'h000;
      nib = 5'h00;
      res = a;
      cOut = cin;
      dcOut = 1'b0;
      case (op)
         rca_pkg::ALU_ADD:
         begin
            sum = {1'b0, a} + {1'b0, w};
            nib = {1'b0, a[3:0]} + {1'b0, w[3:0]};
            res = sum[7:0];
            cOut = sum[8];
            dcOut = nib[4];
         end
         rca_pkg::ALU_SUB:
         begin
            sum = {1'b0, a} + {1'b0, ~w} + 9'h001;
            nib = {1'b0, a[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
            res = sum[7:0];
            cOut = sum[8];
            dcOut = nib[4];
         end
         rca_pkg::ALU_AND: res = a & w;
         rca_pkg::ALU_OR: res = a | w;
         rca_pkg::ALU_XOR: res = a ^ w;
         rca_pkg::ALU_COM: res = ~a;
         rca_pkg::ALU_INC: res = a + 8'h01;
         rca_pkg::ALU_DEC: res = a - 8'h01;
         rca_pkg::ALU_RR:
         begin
            res = {cin, a[7:1]};
            cOut = a[0];
         end
         rca_pkg::ALU_RL:
         begin
            res = {a[6:0], cin};
            cOut = a[7];
         end
         rca_pkg::ALU_SWAP: res = {a[3:0], a[7:4]};
         rca_pkg::ALU_PASSA: res = a;
         rca_pkg::ALU_PASSW: res = w;
         rca_pkg::ALU_ZERO: res = 8'h00;
         default: res = a;
      endcase
   end

   assign zOut = (res == 8'h00);

endmodule : rca_alu

`default_nettype wire

/* rca_cfg.svh */
// Constants of the 8-bit core: widths, addresses, reset values, register map.
// Assumes inclusion by bare name from the package and the core.
`ifndef RCA_CFG_SVH
`define RCA_CFG_SVH

// Datapath widths
`define RCA_INSTR_W 12
`define RCA_DATA_W 8
`define RCA_PC_W 11
`define RCA_FADDR_W 5

// Data memory addresses of the special registers kept inside the core
`define RCA_INDF_ADDR 5'h00
`define RCA_PCL_ADDR 5'h02
`define RCA_STATUS_ADDR 5'h03
`define RCA_FSR_ADDR 5'h04

// Status register bit positions
`define RCA_BIT_C 0
`define RCA_BIT_DC 1
`define RCA_BIT_Z 2
`define RCA_BIT_PD 3
`define RCA_BIT_TO 4
`define RCA_BIT_PA_LO 5
`define RCA_BIT_PA_MID 6
`define RCA_BIT_PA_HI 7

// Reset values
`define RCA_STATUS_RESET 8'h18
`define RCA_RESET_VECTOR 11'h7ff
`define RCA_NOP 12'h000
`define RCA_RUN_RESET 1'b1
`define RCA_VARIANT_RESET 2'h2

// Program memory reach per variant
`define RCA_MASK_512 11'h1ff
`define RCA_MASK_1K 11'h3ff
`define RCA_MASK_2K 11'h7ff

// Bus register byte addresses
`define RCA_APB_AW 12
`define RCA_APB_CTRL 12'h000
`define RCA_APB_STAT 12'h004
`define RCA_APB_ACC 12'h008
`define RCA_APB_PC 12'h00c

// Control register fields
`define RCA_CTRL_RUN 0
`define RCA_CTRL_VAR_LO 1
`define RCA_CTRL_VAR_HI 2
`define RCA_CTRL_WAKE 3
`define RCA_CTRL_ASLEEP 4

`endif

/* rca_core.sv */
// Core of an 8-bit Harvard controller: fetch, two-stage pipeline, ALU, status.
// Assumes program memory answers combinationally to progAddr, the register
// file answers combinationally to fileAddr, and an APB master on mclk.
//
// How it works
// - Twelve-bit opcodes arrive on their own bus, apart from 8-bit data.
// - Next opcode is fetched while the current one executes.
// - Every instruction takes one cycle; branches take two to refill.
// - Eight-bit unit does add, subtract, shifts and Boolean logic.
// - Arithmetic is two's complement unless an instruction says otherwise.
// - Two-operand ops pair accumulator with file or literal; unary act alone.
// - Accumulator is 8 bits and has no data memory address.
// - Special registers incl. program counter sit in data memory; indirect too.
// - Carry, nibble carry and zero flags follow the instruction.
// - On subtract carry and nibble carry show borrow, inverted.
// - Program counter reaches 512, 1K or 2K words per variant.
// - Quarter rate clock pin runs at a quarter of the oscillator.
// - Status register may be the destination of any instruction.
// - Flag-setting ops writing status keep their flag results, not the data.
// - Timeout and powerdown flags ignore every instruction write.
// - Clearing status zeroes page bits, sets zero, keeps the rest.
// - Status holds arithmetic flags, reset-cause flags and page bits.
// - Status sits at address 03h with page, timeout, powerdown, Z, DC, C.
// - On subtract nibble flag is 0 after a borrow from bit 3.
//
// Decided for this implementation: register access over APB and the placing of the registers.
`include "rca_cfg.svh"
`default_nettype none

module rca_core (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`RCA_APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [`RCA_PC_W-1:0] progAddr,
   input wire logic [`RCA_INSTR_W-1:0] progData,
   output logic [`RCA_FADDR_W-1:0] fileAddr,
   input wire logic [`RCA_DATA_W-1:0] fileRdData,
   output logic [`RCA_DATA_W-1:0] fileWrData,
   output logic fileWrEn,
   output logic quarterRateClockPin
);

   rca_pkg::rca_core_s st_ff;
   rca_pkg::rca_core_s nxt_st;
   rca_pkg::rca_phase_e phase;
   rca_pkg::rca_aluop_e aluOp;
   logic [`RCA_DATA_W-1:0] aluA;
   logic [`RCA_DATA_W-1:0] aluRes;
   logic [`RCA_DATA_W-1:0] fileVal;
   logic [`RCA_DATA_W-1:0] bitMask;
   logic [`RCA_DATA_W-1:0] newStatus;
   logic [`RCA_FADDR_W-1:0] effAddr;
   logic [`RCA_PC_W-1:0] pcMask;
   logic [`RCA_PC_W-1:0] seqPc;
   logic [`RCA_PC_W-1:0] target;
   logic [1:0] page;
   logic [2:0] affect;
   logic aluC;
   logic aluDC;
   logic aluZ;
   logic destFile;
   logic destW;
   logic jump;
   logic skip;
   logic callOp;
   logic retOp;
   logic sleepOp;
   logic wdtOp;
   logic commit;
   logic apbDone;

   rca_qdiv u_qdiv (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .phase(phase),
      .clkOut(quarterRateClockPin)
   );

   rca_alu u_alu (
      .op(aluOp),
      .a(aluA),
      .w(st_ff.w),
      .cin(st_ff.status[`RCA_BIT_C]),
      .res(aluRes),
      .cOut(aluC),
      .dcOut(aluDC),
      .zOut(aluZ)
   );

   // Execution commits once per instruction cycle, at the end of phase 2
   assign commit = (phase == rca_pkg::PH_Q2) && st_ff.run && !st_ff.asleep;
   assign apbDone = psel && penable && st_ff.pready;
   assign page = st_ff.status[`RCA_BIT_PA_MID:`RCA_BIT_PA_LO];
   assign seqPc = (st_ff.progAddr + 11'h001) & pcMask;
   assign bitMask = 8'h01 << st_ff.instr[7:5];

   // Smaller variants simply wrap inside their own reach
   always_comb
   begin
      case (st_ff.variant)
         2'h0: pcMask = `RCA_MASK_512;
         2'h1: pcMask = `RCA_MASK_1K;
         default: pcMask = `RCA_MASK_2K;
      endcase
   end

   // Indirect through the select register when address zero is named
   always_comb
   begin
      effAddr = (st_ff.instr[4:0] == `RCA_INDF_ADDR) ? st_ff.fsr[4:0] : st_ff.instr[4:0];
      case (effAddr)
         `RCA_PCL_ADDR: fileVal = st_ff.progAddr[7:0];
         `RCA_STATUS_ADDR: fileVal = st_ff.status;
         `RCA_FSR_ADDR: fileVal = st_ff.fsr;
         `RCA_INDF_ADDR: fileVal = 8'h00;
         default: fileVal = fileRdData;
      endcase
   end

   // Instruction decode; affect is {zero, nibble carry, carry}
   always_comb
   begin
      aluOp = rca_pkg::ALU_PASSA;
      aluA = st_ff.opnd;
      affect = 3'h0;
      destFile = 1'b0;
      destW = 1'b0;
      jump = 1'b0;
      skip = 1'b0;
      callOp = 1'b0;
      retOp = 1'b0;
      sleepOp = 1'b0;
      wdtOp = 1'b0;
      target = seqPc;
      casez (st_ff.instr[11:8])
         4'b00??:
         begin
            destFile = st_ff.instr[5];
            destW = !st_ff.instr[5];
            case (st_ff.instr[11:6])
               rca_pkg::BYTE_MISC:
               begin
                  aluOp = rca_pkg::ALU_PASSW;
                  destW = 1'b0;
                  sleepOp = !st_ff.instr[5] && (st_ff.instr[4:0] == 5'h03);
                  wdtOp = !st_ff.instr[5] && (st_ff.instr[4:0] == 5'h04);
               end
               rca_pkg::BYTE_CLR:
               begin
                  aluOp = rca_pkg::ALU_ZERO;
                  affect = 3'h4;
               end
               rca_pkg::BYTE_SUB:
               begin
                  aluOp = rca_pkg::ALU_SUB;
                  affect = 3'h7;
               end
               rca_pkg::BYTE_ADD:
               begin
                  aluOp = rca_pkg::ALU_ADD;
                  affect = 3'h7;
               end
               rca_pkg::BYTE_DEC:
               begin
                  aluOp = rca_pkg::ALU_DEC;
                  affect = 3'h4;
               end
               rca_pkg::BYTE_INC:
               begin
                  aluOp = rca_pkg::ALU_INC;
                  affect = 3'h4;
               end
               rca_pkg::BYTE_IOR:
               begin
                  aluOp = rca_pkg::ALU_OR;
                  affect = 3'h4;
               end
               rca_pkg::BYTE_AND:
               begin
                  aluOp = rca_pkg::ALU_AND;
                  affect = 3'h4;
               end
               rca_pkg::BYTE_XOR:
               begin
                  aluOp = rca_pkg::ALU_XOR;
                  affect = 3'h4;
               end
               rca_pkg::BYTE_MOV: affect = 3'h4;
               rca_pkg::BYTE_COM:
               begin
                  aluOp = rca_pkg::ALU_COM;
                  affect = 3'h4;
               end
               rca_pkg::BYTE_RR:
               begin
                  aluOp = rca_pkg::ALU_RR;
                  affect = 3'h1;
               end
               rca_pkg::BYTE_RL:
               begin
                  aluOp = rca_pkg::ALU_RL;
                  affect = 3'h1;
               end
               rca_pkg::BYTE_SWAP: aluOp = rca_pkg::ALU_SWAP;
               rca_pkg::BYTE_DECSZ:
               begin
                  aluOp = rca_pkg::ALU_DEC;
                  skip = aluZ;
               end
               rca_pkg::BYTE_INCSZ:
               begin
                  aluOp = rca_pkg::ALU_INC;
                  skip = aluZ;
               end
               default: aluOp = rca_pkg::ALU_PASSA;
            endcase
         end
         4'b01??:
         begin
            // Bit ops touch no flags, the safe way to edit status
            destFile = !st_ff.instr[9];
            aluA = st_ff.instr[8] ? (st_ff.opnd | bitMask) : (st_ff.opnd & ~bitMask);
            if (st_ff.instr[9])
            begin
               skip = st_ff.instr[8] ? |(st_ff.opnd & bitMask) : ~|(st_ff.opnd & bitMask);
            end
         end
         4'b1000:
         begin
            aluA = st_ff.instr[7:0];
            destW = 1'b1;
            retOp = 1'b1;
            jump = 1'b1;
            target = st_ff.stack0;
         end
         4'b1001:
         begin
            callOp = 1'b1;
            jump = 1'b1;
            target = {page, 1'b0, st_ff.instr[7:0]};
         end
         4'b101?:
         begin
            jump = 1'b1;
            target = {page, st_ff.instr[8:0]};
         end
         4'b11??:
         begin
            aluA = st_ff.instr[7:0];
            destW = 1'b1;
            case (st_ff.instr[9:8])
               2'h1: aluOp = rca_pkg::ALU_OR;
               2'h2: aluOp = rca_pkg::ALU_AND;
               2'h3: aluOp = rca_pkg::ALU_XOR;
               default: aluOp = rca_pkg::ALU_PASSA;
            endcase
            affect = (st_ff.instr[9:8] == 2'h0) ? 3'h0 : 3'h4;
         end
         default: aluOp = rca_pkg::ALU_PASSA;
      endcase
      // A computed jump: writing the low counter byte
      if (destFile && (effAddr == `RCA_PCL_ADDR))
      begin
         jump = 1'b1;
         target = {page, 1'b0, aluRes};
      end
   end

   // Status after a write: page bits always take data; Z, DC, C take it only when the op leaves all flags alone
   always_comb
   begin
      newStatus = st_ff.status;
      if (destFile && (effAddr == `RCA_STATUS_ADDR))
      begin
         newStatus[7:5] = aluRes[7:5];
         if (affect == 3'h0)
         begin
            newStatus[2:0] = aluRes[2:0];
         end
      end
      if (affect[2])
      begin
         newStatus[`RCA_BIT_Z] = aluZ;
      end
      if (affect[1])
      begin
         newStatus[`RCA_BIT_DC] = aluDC;
      end
      if (affect[0])
      begin
         newStatus[`RCA_BIT_C] = aluC;
      end
      newStatus[`RCA_BIT_TO] = st_ff.status[`RCA_BIT_TO] | sleepOp | wdtOp;
      newStatus[`RCA_BIT_PD] = (st_ff.status[`RCA_BIT_PD] & !sleepOp) | wdtOp;
   end

   // Whole next state; APB answers one cycle into the access phase
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.fileWrEn = 1'b0;
      nxt_st.pready = 1'b0;
      nxt_st.pslverr = 1'b0;
      if (phase == rca_pkg::PH_Q0)
      begin
         nxt_st.fileAddr = effAddr;
      end
      if (phase == rca_pkg::PH_Q1)
      begin
         nxt_st.opnd = fileVal;
      end
      if (commit)
      begin
         nxt_st.instr = (jump || skip) ? `RCA_NOP : progData;
         nxt_st.progAddr = jump ? (target & pcMask) : seqPc;
         nxt_st.status = newStatus;
         if (callOp)
         begin
            nxt_st.stack1 = st_ff.stack0;
            nxt_st.stack0 = st_ff.progAddr;
         end
         if (retOp)
         begin
            nxt_st.stack0 = st_ff.stack1;
         end
         if (sleepOp)
         begin
            nxt_st.asleep = 1'b1;
         end
         if (destW)
         begin
            nxt_st.w = aluRes;
         end
         if (destFile && (effAddr == `RCA_FSR_ADDR))
         begin
            nxt_st.fsr = aluRes;
         end
         if (destFile && (effAddr > `RCA_FSR_ADDR))
         begin
            nxt_st.fileWrEn = 1'b1;
            nxt_st.fileWrData = aluRes;
         end
      end
      if (psel && penable && !st_ff.pready)
      begin
         nxt_st.pready = 1'b1;
         nxt_st.prdata = 32'h0000_0000;
         case (paddr)
            `RCA_APB_CTRL: nxt_st.prdata = {27'h0, st_ff.asleep, 1'b0, st_ff.variant,
               st_ff.run};
            `RCA_APB_STAT: nxt_st.prdata = {24'h0, st_ff.status};
            `RCA_APB_ACC: nxt_st.prdata = {24'h0, st_ff.w};
            `RCA_APB_PC: nxt_st.prdata = {21'h0, st_ff.progAddr};
            default: nxt_st.pslverr = 1'b1;
         endcase
      end
      if (apbDone && pwrite && (paddr == `RCA_APB_CTRL))
      begin
         nxt_st.run = pwdata[`RCA_CTRL_RUN];
         nxt_st.variant = pwdata[`RCA_CTRL_VAR_HI:`RCA_CTRL_VAR_LO];
         // A sleep committing in the same cycle wins over the wake request
         if (pwdata[`RCA_CTRL_WAKE] && !(commit && sleepOp))
         begin
            nxt_st.asleep = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         st_ff <= '0;
         st_ff.progAddr <= `RCA_RESET_VECTOR;
         st_ff.status <= `RCA_STATUS_RESET;
         st_ff.run <= `RCA_RUN_RESET;
         st_ff.variant <= `RCA_VARIANT_RESET;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign prdata = st_ff.prdata;
   assign pready = st_ff.pready;
   assign pslverr = st_ff.pslverr;
   assign progAddr = st_ff.progAddr;
   assign fileAddr = st_ff.fileAddr;
   assign fileWrData = st_ff.fileWrData;
   assign fileWrEn = st_ff.fileWrEn;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   fetch_bus_a: assert property (commit && !jump && !skip |=> st_ff.instr == $past(progData))
      else $error("fetched opcode not loaded");
   pipe_hold_a: assert property (!commit |=> $stable(st_ff.progAddr) && $stable(st_ff.instr))
      else $error("fetch state moved outside commit");
   branch_refill_a: assert property (commit && jump |=> st_ff.instr == `RCA_NOP)
      else $error("branch did not refill pipeline");
   cycle_len_a: assert property (commit |=> !commit [*3])
      else $error("instruction cycle shorter than four clocks");
   acc_only_commit_a: assert property (!commit |=> $stable(st_ff.w))
      else $error("accumulator changed outside commit");
   reset_flags_a: assert property (commit && !sleepOp && !wdtOp
      |=> $stable(st_ff.status[`RCA_BIT_TO]) && $stable(st_ff.status[`RCA_BIT_PD]))
      else $error("timeout or powerdown flag written");
   zero_flag_a: assert property (commit && affect[2]
      |=> st_ff.status[`RCA_BIT_Z] == ($past(aluRes) == 8'h00))
      else $error("zero flag wrong");
   sub_borrow_a: assert property (commit && (aluOp == rca_pkg::ALU_SUB) && affect[0]
      |=> st_ff.status[`RCA_BIT_C] == ($past(st_ff.opnd) >= $past(st_ff.w))
      && st_ff.status[`RCA_BIT_DC] == ($past(st_ff.opnd[3:0]) >= $past(st_ff.w[3:0])))
      else $error("subtract borrow flags wrong");
   clr_status_a: assert property (commit && destFile && (aluOp == rca_pkg::ALU_ZERO)
      && (effAddr == `RCA_STATUS_ADDR) |=> st_ff.status[7:5] == 3'h0
      && st_ff.status[`RCA_BIT_Z] && $stable(st_ff.status[1:0]))
      else $error("clearing status gave wrong pattern");
   flag_guard_a: assert property (commit && destFile && (effAddr == `RCA_STATUS_ADDR)
      && affect[0] |=> st_ff.status[`RCA_BIT_C] == $past(aluC))
      else $error("status write overrode carry result");

   branch_cov: cover property (commit && jump);
   skip_cov: cover property (commit && skip);
   status_wr_cov: cover property (commit && destFile && (effAddr == `RCA_STATUS_ADDR));
   sleep_cov: cover property (commit && sleepOp);

endmodule : rca_core

`default_nettype wire

/* rca_mem_model.sv */
// Model of program memory and the register file beside the core.
// Assumes the bench loads prog and regs before reset is released.
`default_nettype none
module rca_mem_model (
   input wire logic mclk,
   input wire logic [10:0] progAddr,
   output logic [11:0] progData,
   input wire logic [4:0] fileAddr,
   output logic [7:0] fileRdData,
   input wire logic [7:0] fileWrData,
   input wire logic fileWrEn
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] prog [2048];
   logic [7:0] regs [32];
   // Combinational answers, as the core samples them late in the cycle
   assign progData = prog[progAddr];
   assign fileRdData = regs[fileAddr];
   // One byte per strobe
   always_ff @(posedge mclk)
   begin
      if (fileWrEn)
      begin
         regs[fileAddr] <= fileWrData;
      end
   end
endmodule : rca_mem_model
`default_nettype wire

/* rca_pkg.sv */
// Types shared by the core, its arithmetic unit and its phase divider.
// Assumes rca_cfg.svh is on the include path.
`include "rca_cfg.svh"
`default_nettype none

package rca_pkg;

   // Quarter-rate phases, one-hot
   typedef enum logic [3:0] {
      PH_Q0 = 4'h1,
      PH_Q1 = 4'h2,
      PH_Q2 = 4'h4,
      PH_Q3 = 4'h8
   } rca_phase_e;

   // Arithmetic unit operations
   typedef enum logic [3:0] {
      ALU_ADD = 4'h0, ALU_SUB = 4'h1, ALU_AND = 4'h2, ALU_OR = 4'h3,
      ALU_XOR = 4'h4, ALU_COM = 4'h5, ALU_INC = 4'h6, ALU_DEC = 4'h7,
      ALU_RR = 4'h8, ALU_RL = 4'h9, ALU_SWAP = 4'ha, ALU_PASSA = 4'hb,
      ALU_PASSW = 4'hc, ALU_ZERO = 4'hd
   } rca_aluop_e;

   // Upper six opcode bits of the byte-oriented file operations
   typedef enum logic [5:0] {
      BYTE_MISC = 6'h00, BYTE_CLR = 6'h01, BYTE_SUB = 6'h02, BYTE_DEC = 6'h03,
      BYTE_IOR = 6'h04, BYTE_AND = 6'h05, BYTE_XOR = 6'h06, BYTE_ADD = 6'h07,
      BYTE_MOV = 6'h08, BYTE_COM = 6'h09, BYTE_INC = 6'h0a, BYTE_DECSZ = 6'h0b,
      BYTE_RR = 6'h0c, BYTE_RL = 6'h0d, BYTE_SWAP = 6'h0e, BYTE_INCSZ = 6'h0f
   } rca_byteop_e;

   typedef struct packed {
      rca_phase_e phase;
      logic clkOut;
   } rca_qdiv_s;

   typedef struct packed {
      logic [`RCA_INSTR_W-1:0] instr;
      logic [`RCA_PC_W-1:0] progAddr;
      logic [`RCA_DATA_W-1:0] w;
      logic [`RCA_DATA_W-1:0] status;
      logic [`RCA_DATA_W-1:0] fsr;
      logic [`RCA_PC_W-1:0] stack0;
      logic [`RCA_PC_W-1:0] stack1;
      logic [`RCA_DATA_W-1:0] opnd;
      logic [`RCA_FADDR_W-1:0] fileAddr;
      logic [`RCA_DATA_W-1:0] fileWrData;
      logic fileWrEn;
      logic run;
      logic [1:0] variant;
      logic asleep;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } rca_core_s;

endpackage : rca_pkg

`default_nettype wire

/* rca_qdiv.sv */
// Divides the oscillator clock into the four phases of an instruction cycle.
// Assumes mclk is the oscillator; the pin output is high in phases 2 and 3.
`include "rca_cfg.svh"
`default_nettype none

module rca_qdiv (
   input wire logic mclk,
   input wire logic sys_rst,
   output var rca_pkg::rca_phase_e phase,
   output logic clkOut
);

   rca_pkg::rca_qdiv_s st_ff;
   rca_pkg::rca_qdiv_s nxt_st;

   // Phase ring; pin level follows the next phase so it stays a flop output
   always_comb
   begin
      nxt_st = st_ff;
      case (st_ff.phase)
         rca_pkg::PH_Q0: nxt_st.phase = rca_pkg::PH_Q1;
         rca_pkg::PH_Q1: nxt_st.phase = rca_pkg::PH_Q2;
         rca_pkg::PH_Q2: nxt_st.phase = rca_pkg::PH_Q3;
         rca_pkg::PH_Q3: nxt_st.phase = rca_pkg::PH_Q0;
         default: nxt_st.phase = rca_pkg::PH_Q0;
      endcase
      nxt_st.clkOut = (nxt_st.phase == rca_pkg::PH_Q2) || (nxt_st.phase == rca_pkg::PH_Q3);
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         st_ff.phase <= rca_pkg::PH_Q0;
         st_ff.clkOut <= 1'b0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign phase = st_ff.phase;
   assign clkOut = st_ff.clkOut;

   quarter_clk_a: assert property (@(posedge mclk) disable iff (sys_rst)
      $rose(clkOut) |=> clkOut ##1 !clkOut ##1 !clkOut ##1 clkOut)
      else $error("quarter rate clock pin lost its divide-by-four shape");

endmodule : rca_qdiv

`default_nettype wire

/* testbench.sv */
// Bench: runs a short program, snapshots status into file registers, reads over APB.
// Assumes rca_core and rca_mem_model; a single clock.
`include "rca_cfg.svh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, fileWrEn, pin, err;
   logic [11:0] paddr, progData;
   logic [31:0] pwdata, prdata, rd;
   logic [10:0] progAddr;
   logic [4:0] fileAddr;
   logic [7:0] fileRdData, fileWrData, sh;
   int num_errors = 0, num_checks = 0, cycles = 0;
   // Snapshots land at 10h..17h; flag words taken by a move from status
   // Ends with call, literal return, store and sleep, so the PC freezes at 1ch
   // Status is set by an accumulator move; flag ops on status probe clearing and the guard
   localparam logic [11:0] CODE [29] = '{12'hc88, 12'h030, 12'h1d0, 12'h203, 12'h031,
      12'hc89, 12'h090, 12'h203, 12'h032, 12'hc88, 12'h090, 12'h203, 12'h033, 12'hce7,
      12'h023, 12'h203, 12'h034, 12'h063, 12'h203, 12'h035, 12'hc00, 12'h1e3, 12'h203,
      12'h036, 12'h91c, 12'h037, 12'h003, 12'ha1b, 12'h8a5};
   localparam logic [7:0] EXP [8] = '{8'h88, 8'h1b, 8'h18, 8'h1f, 8'hff, 8'h1f, 8'h18, 8'ha5};
   rca_core i_rca_core (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .progAddr(progAddr), .progData(progData), .fileAddr(fileAddr),
      .fileRdData(fileRdData), .fileWrData(fileWrData), .fileWrEn(fileWrEn),
      .quarterRateClockPin(pin));
   rca_mem_model i_rca_mem_model (.mclk(mclk), .progAddr(progAddr), .progData(progData),
      .fileAddr(fileAddr), .fileRdData(fileRdData), .fileWrData(fileWrData),
      .fileWrEn(fileWrEn));
   // 10 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] expv);
      num_checks++;
      if (seen !== expv)
      begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, expv);
      end
   endtask : check
   // Held until pready is sampled high; the core always answers
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb
   task automatic complete_run();
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : complete_run
   // Hang guard; the whole run needs well under 1000 cycles
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         num_errors++;
         complete_run();
      end
   end
   // Main sequence
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      sys_rst = 1'b1;
      for (int i = 0; i < 2048; i++) i_rca_mem_model.prog[i] = (i < 29) ? CODE[i] : 12'h000;
      for (int i = 0; i < 32; i++) i_rca_mem_model.regs[i] = 8'h5a;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge mclk);
      for (int i = 0; i < 8; i++)
      begin
         @(posedge mclk);
         sh[i] = pin;
      end
      check(sh ^ {sh[5:0], sh[7:6]}, 8'hff);
      $display("clock pin test done");
      repeat (300) @(posedge mclk);
      for (int i = 0; i < 4; i++)
         check(i_rca_mem_model.regs[16 + i], EXP[i]);
      for (int i = 4; i < 8; i++)
         check(i_rca_mem_model.regs[16 + i], EXP[i]);
      $display("program test done");
      // Sleep left timeout set and powerdown clear
      apb(1'b0, `RCA_APB_STAT, 32'h0);
      check(rd, 32'h10);
      apb(1'b0, `RCA_APB_ACC, 32'h0);
      check(rd, 32'ha5);
      apb(1'b0, `RCA_APB_CTRL, 32'h0);
      check(rd, 32'h15);
      apb(1'b0, `RCA_APB_PC, 32'h0);
      check(rd, 32'h1c);
      apb(1'b1, `RCA_APB_STAT, 32'h0);
      apb(1'b0, `RCA_APB_STAT, 32'h0);
      check(rd, 32'h10);
      apb(1'b0, 12'h010, 32'h0);
      check({rd[30:0], err}, 32'h1);
      // Wake with the smallest variant, then read the control word back
      apb(1'b1, `RCA_APB_CTRL, 32'h9);
      apb(1'b0, `RCA_APB_CTRL, 32'h0);
      check(rd, 32'h1);
      $display("bus test done");
      complete_run();
   end
endmodule : testbench
`default_nettype wire
